// *** fspc_pkg.sv ***
/*
  Constants for the flash self-program controller: register map, command
  bit positions, accepted command patterns, state codes, timing counts.
  Assumes a 100 MHz system clock.
*/
package fspc_pkg;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STAT = 32'h0000_0004;

  localparam int B_SPE = 0;
  localparam int B_PGE = 1;
  localparam int B_PGW = 2;
  localparam int B_RFL = 3;
  localparam int B_CLR = 4;
  localparam int S_BUSY = 0;
  localparam int S_FILL = 1;

  localparam logic [4:0] CTRL_RST  = 5'h00;
  localparam logic [4:0] CMD_LOAD  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_RFL   = 5'h09;
  localparam logic [4:0] CMD_CLR   = 5'h11;

  localparam logic [15:0] BUF_ERASED = 16'hFFFF;
  localparam logic [5:0]  LOCK_PAD   = 6'h3F;

  localparam logic [2:0] ARM_CYC = 3'h4;
  localparam logic [2:0] LPM_CYC = 3'h3;

  localparam int CLK_PERIOD_NS = 10;
  localparam int OP_MIN_NS     = 3700000;
  localparam int OP_MAX_NS     = 4500000;
  localparam int OP_MIN_CYC    =
    (OP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OP_MAX_CYC    = OP_MAX_NS / CLK_PERIOD_NS;

  localparam int PAGE_WORDS_DEF = 16;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_ARMED = 3'h2,
    ST_BUSY  = 3'h4
  } fspc_state_t;
endpackage

// *** fspc_ctrl.sv ***
/*
  Flash self-program controller: control register on AHB-Lite, arming
  window for store/load instructions, temporary page buffer, page erase
  and page write sequencing with CPU stall, fuse and lock readback.
  Assumes the CPU core gives one-cycle store/load strobes with pointer
  and data pair, and that the flash macro accepts one word per cycle.
*/
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
module fspc_ctrl #(
  parameter  int PAGE_WORDS = fspc_pkg::PAGE_WORDS_DEF,
  parameter  int OP_CYCLES  = fspc_pkg::OP_MIN_CYC,
  localparam int WB         = $clog2(PAGE_WORDS),
  localparam int PB         = 15 - WB
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic          hready,
  input  wire logic [31:0]   hwdata,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic          spm_req,
  input  wire logic          lpm_req,
  input  wire logic [15:0]   ptr,
  input  wire logic [15:0]   data_pair,
  input  wire logic          eeprom_write_busy,
  input  wire logic [7:0]    fuse_low_prog,
  input  wire logic [7:0]    fuse_high_prog,
  input  wire logic [1:0]    lock_prog,
  output logic               cpu_stall,
  output logic               lpm_hit,
  output logic      [7:0]    lpm_data,
  output logic               flash_erase_start,
  output logic               flash_prog_we,
  output logic      [PB-1:0] flash_page,
  output logic      [WB-1:0] flash_prog_addr,
  output logic      [15:0]   flash_prog_data
);
  import fspc_pkg::*;

  localparam int TW = $clog2(OP_CYCLES + 1);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // bus data phase
  logic        dwr_q;
  logic        dwr_d;
  logic [31:0] daddr_q;
  logic [31:0] daddr_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic        ap_ok;
  logic        ctrl_wr;
  logic [4:0]  wcmd;

  // control state
  fspc_state_t   st_q;
  fspc_state_t   st_d;
  logic [4:0]    ctrl_q;
  logic [4:0]    ctrl_d;
  logic [2:0]    cnt_q;
  logic [2:0]    cnt_d;
  logic [TW-1:0] tmr_q;
  logic [TW-1:0] tmr_d;
  logic [WB:0]   wi_q;
  logic [WB:0]   wi_d;
  logic          hit_q;
  logic          hit_d;
  logic [7:0]    ldat_q;
  logic [7:0]    ldat_d;
  logic          ers_q;
  logic          ers_d;
  logic          we_q;
  logic          we_d;
  logic [PB-1:0] pg_q;
  logic [PB-1:0] pg_d;
  logic [WB-1:0] pa_q;
  logic [WB-1:0] pa_d;
  logic [15:0]   pd_q;
  logic [15:0]   pd_d;
  logic          ee_q;
  logic          buf_ld;
  logic          buf_clr;
  logic          ee_rise;
  logic          cmd_ok;
  logic          store;
  logic          fetch;

  // page buffer
  logic [15:0]         buf_q [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] vld_q;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdat_q;

  assign ap_ok   = hsel && hready && htrans[1];
  assign ctrl_wr = dwr_q && (daddr_q == ADDR_CTRL);
  assign wcmd    = hwdata[4:0];
  // EEPROM activity refuses stores and fuse reads as well
  assign store   = spm_req && !eeprom_write_busy;
  assign fetch   = lpm_req && !eeprom_write_busy;
  assign cmd_ok  = (wcmd == CMD_LOAD) || (wcmd == CMD_ERASE) ||
                   (wcmd == CMD_WRITE) || (wcmd == CMD_RFL) ||
                   (wcmd == CMD_CLR);
  // only a starting EEPROM write while words are held matters
  assign ee_rise = eeprom_write_busy && !ee_q && (|vld_q);

  always_comb begin
    dwr_d   = ap_ok && hwrite;
    daddr_d = haddr;
    rdat_d  = rdat_q;
    if (ap_ok && !hwrite) begin
      if (haddr == ADDR_CTRL) begin
        rdat_d = {27'h0, ctrl_q};
      end else if (haddr == ADDR_STAT) begin
        rdat_d = 32'h0;
        rdat_d[S_BUSY] = st_q == ST_BUSY;
        rdat_d[S_FILL] = |vld_q;
      end else begin
        rdat_d = 32'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dwr_q   <= 1'b0;
      daddr_q <= 32'h0;
      rdat_q  <= 32'h0;
    end else begin
      dwr_q   <= dwr_d;
      daddr_q <= daddr_d;
      rdat_q  <= rdat_d;
    end
  end

  always_comb begin
    st_d    = st_q;
    ctrl_d  = ctrl_q;
    cnt_d   = cnt_q;
    tmr_d   = tmr_q;
    wi_d    = wi_q;
    hit_d   = 1'b0;
    ldat_d  = ldat_q;
    ers_d   = 1'b0;
    we_d    = 1'b0;
    pg_d    = pg_q;
    pa_d    = pa_q;
    pd_d    = pd_q;
    buf_ld  = 1'b0;
    buf_clr = 1'b0;
    case (st_q)
      ST_ARMED: begin
        cnt_d = cnt_q + 3'h1;
        if (ctrl_q[B_RFL]) begin
          if (fetch) begin
            hit_d = 1'b1;
            // programmed fuses are held as ones, so invert
            // pointer 2 is undefined and falls back to the low fuse
            if (ptr[1:0] == 2'h1) begin
              ldat_d = {LOCK_PAD, ~lock_prog};
            end else if (ptr[1:0] == 2'h3) begin
              ldat_d = ~fuse_high_prog;
            end else begin
              ldat_d = ~fuse_low_prog;
            end
            ctrl_d = CTRL_RST;
            st_d   = ST_IDLE;
          end else if (cnt_q == LPM_CYC - 3'h1) begin
            ctrl_d = CTRL_RST;
            st_d   = ST_IDLE;
          end
        end else if (store) begin
          case (ctrl_q)
            CMD_LOAD: begin
              buf_ld = 1'b1;
              ctrl_d = CTRL_RST;
              st_d   = ST_IDLE;
            end
            CMD_ERASE: begin
              ers_d = 1'b1;
              pg_d  = ptr[15:WB+1];
              tmr_d = '0;
              st_d  = ST_BUSY;
            end
            CMD_WRITE: begin
              pg_d  = ptr[15:WB+1];
              tmr_d = '0;
              wi_d  = '0;
              st_d  = ST_BUSY;
            end
            default: begin
              ctrl_d = CTRL_RST;
              st_d   = ST_IDLE;
            end
          endcase
        end else if (cnt_q == ARM_CYC - 3'h1) begin
          ctrl_d = CTRL_RST;
          st_d   = ST_IDLE;
        end
      end
      ST_BUSY: begin
        // command bits, enable included, hold until done
        tmr_d = tmr_q + TW'(1);
        if (ctrl_q[B_PGW] && (wi_q < (WB+1)'(PAGE_WORDS))) begin
          we_d = 1'b1;
          pa_d = wi_q[WB-1:0];
          pd_d = buf_q[wi_q[WB-1:0]];
          wi_d = wi_q + (WB+1)'(1);
        end
        if (tmr_q == TW'(OP_CYCLES - 1)) begin
          buf_clr = ctrl_q[B_PGW];
          ctrl_d  = CTRL_RST;
          st_d    = ST_IDLE;
        end
      end
      default: begin
        st_d = st_q;
      end
    endcase
    // new command replaces an open window; ignored while stalled
    if (ctrl_wr && st_q != ST_BUSY && !eeprom_write_busy && cmd_ok) begin
      ctrl_d = wcmd;
      st_d   = ST_ARMED;
      cnt_d  = 3'h0;
      buf_ld = 1'b0;
      if (wcmd[B_CLR]) begin
        buf_clr = 1'b1;
      end
    end
    if (ee_rise) begin
      buf_clr = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q   <= ST_IDLE;
      ctrl_q <= CTRL_RST;
      cnt_q  <= 3'h0;
      tmr_q  <= '0;
      wi_q   <= '0;
      hit_q  <= 1'b0;
      ldat_q <= 8'h00;
      ers_q  <= 1'b0;
      we_q   <= 1'b0;
      pg_q   <= '0;
      pa_q   <= '0;
      pd_q   <= 16'h0000;
      ee_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      ctrl_q <= ctrl_d;
      cnt_q  <= cnt_d;
      tmr_q  <= tmr_d;
      wi_q   <= wi_d;
      hit_q  <= hit_d;
      ldat_q <= ldat_d;
      ers_q  <= ers_d;
      we_q   <= we_d;
      pg_q   <= pg_d;
      pa_q   <= pa_d;
      pd_q   <= pd_d;
      ee_q   <= eeprom_write_busy;
    end
  end

  // a second load to one word overwrites; software must not rely on it
  for (genvar i = 0; i < PAGE_WORDS; i++) begin : g_buf
    logic [15:0] bd;
    logic        vd;
    logic        hit;
    assign hit = buf_ld && (ptr[WB:1] == WB'(i));
    always_comb begin
      bd = buf_q[i];
      vd = vld_q[i];
      if (buf_clr) begin
        bd = BUF_ERASED;
        vd = 1'b0;
      end else if (hit) begin
        bd = data_pair;
        vd = 1'b1;
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        buf_q[i] <= BUF_ERASED;
        vld_q[i] <= 1'b0;
      end else begin
        buf_q[i] <= bd;
        vld_q[i] <= vd;
      end
    end
  end

  assign cpu_stall         = st_q == ST_BUSY;
  assign lpm_hit           = hit_q;
  assign lpm_data          = ldat_q;
  assign flash_erase_start = ers_q;
  assign flash_prog_we     = we_q;
  assign flash_page        = pg_q;
  assign flash_prog_addr   = pa_q;
  assign flash_prog_data   = pd_q;

  // helper: length of the current stall
  logic [TW:0] slen_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slen_q <= '0;
    end else begin
      slen_q <= cpu_stall ? slen_q + (TW+1)'(1) : '0;
    end
  end

  AST_ERASE_GO: assert property (
    (st_q == ST_ARMED && ctrl_q == CMD_ERASE && store && !ctrl_wr)
    |=> flash_erase_start && cpu_stall && flash_page == $past(ptr[15:WB+1]))
    else $error("erase did not start");

  AST_STALL_LEN: assert property (
    $fell(cpu_stall) |-> slen_q == (TW+1)'(OP_CYCLES))
    else $error("stall length wrong");

  AST_SPE_HELD: assert property (
    cpu_stall |-> ctrl_q[B_SPE] && (ctrl_q[B_PGE] || ctrl_q[B_PGW]))
    else $error("enable dropped during operation");

  AST_EXPIRE: assert property (
    (st_q == ST_ARMED && !ctrl_q[B_RFL] && cnt_q == 3'h3 && !store
     && !ctrl_wr) |=> ctrl_q == CTRL_RST && st_q == ST_IDLE)
    else $error("window did not expire at four");

  AST_RFL_EXPIRE: assert property (
    (st_q == ST_ARMED && ctrl_q[B_RFL] && cnt_q == 3'h2 && !fetch
     && !ctrl_wr) |=> ctrl_q == CTRL_RST)
    else $error("fuse window did not expire at three");

  AST_BAD_CMD: assert property (
    (ctrl_wr && !cmd_ok && st_q == ST_IDLE && !ee_rise)
    |=> $stable(ctrl_q) && st_q == ST_IDLE && $stable(vld_q))
    else $error("invalid command had an effect");

  AST_EE_BLOCK: assert property (
    (ctrl_wr && eeprom_write_busy && st_q == ST_IDLE)
    |=> ctrl_q == CTRL_RST)
    else $error("command taken during eeprom write");

  AST_LOCK_READ: assert property (
    (st_q == ST_ARMED && ctrl_q[B_RFL] && fetch && ptr[1:0] == 2'h1
     && !ctrl_wr)
    |=> (lpm_hit && lpm_data == {LOCK_PAD, ~$past(lock_prog)})
    ##1 !lpm_hit)
    else $error("lock readback wrong");

  AST_BUF_CLR: assert property (
    (cpu_stall && ctrl_q[B_PGW] && tmr_q == TW'(OP_CYCLES - 1))
    |=> vld_q == '0 && !cpu_stall)
    else $error("buffer not cleared after write");

  AST_EE_DISCARD: assert property (
    ee_rise |=> vld_q == '0)
    else $error("buffer kept across eeprom write");

  AST_WRITE_WORDS: assert property (
    (st_q == ST_ARMED && ctrl_q == CMD_WRITE && store && !ctrl_wr)
    |=> !flash_prog_we ##1 flash_prog_we && flash_prog_addr == '0)
    else $error("page write copy did not start");
endmodule

// *** fspc_cpu_model.sv ***
/*
  CPU core model for the flash self-program controller: issues store and
  load strobes with pointer and data pair. Assumes rising-edge hclk and
  callers that start just after a clock edge.
*/
`timescale 1ns/1ns
module fspc_cpu_model (
  input  wire logic        hclk,
  input  wire logic        cpu_stall,
  input  wire logic        lpm_hit,
  input  wire logic [7:0]  lpm_data,
  output logic             spm_req,
  output logic             lpm_req,
  output logic      [15:0] ptr,
  output logic      [15:0] data_pair
);
  initial begin
    spm_req   = 1'b0;
    lpm_req   = 1'b0;
    ptr       = 16'h0000;
    data_pair = 16'h0000;
  end

  task automatic issue(input logic ld, input logic [15:0] p,
                       input logic [15:0] d);
    int n;
    n = 0;
    // halted core fetches nothing
    while (cpu_stall === 1'b1 && n < 1000) begin
      @(posedge hclk);
      n++;
    end
    spm_req   <= ~ld;
    lpm_req   <= ld;
    ptr       <= p;
    data_pair <= d;
    @(posedge hclk);
    spm_req   <= 1'b0;
    lpm_req   <= 1'b0;
    // released lines must not keep the last value
    ptr       <= ~p;
    data_pair <= ~d;
  endtask

  task automatic load(input logic [15:0] p, output logic hit,
                      output logic [7:0] v);
    issue(1'b1, p, 16'h0000);
    #1;
    hit = lpm_hit;
    v   = lpm_data;
  endtask
endmodule

// *** tb_top.sv ***
/*
  Self-checking bench for fspc_ctrl: AHB-Lite register access, CPU model
  strobes, flash write capture. Assumes zero-wait-state slave, short
  operation time and an 8-word page.
*/
`timescale 1ns/1ns
module tb_top;
  import fspc_pkg::*;
  localparam int PW  = 8;
  localparam int OPC = 40;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        spm_req, lpm_req, eeprom_write_busy, cpu_stall, lpm_hit;
  logic        flash_erase_start, flash_prog_we, hit;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, lock_prog;
  logic [2:0]  hsize, flash_prog_addr;
  logic [15:0] ptr, data_pair, flash_prog_data;
  logic [7:0]  fuse_low_prog, fuse_high_prog, lpm_data, v;
  logic [11:0] flash_page, wpage, epage, pg;
  logic [15:0] cap [PW];
  logic [15:0] exp_buf [PW];
  int          num_errors, checks, scnt, slen, wcnt, ecnt, cyc;

  fspc_ctrl #(.PAGE_WORDS(PW), .OP_CYCLES(OPC)) fspc_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .spm_req(spm_req), .lpm_req(lpm_req), .ptr(ptr), .data_pair(data_pair),
    .eeprom_write_busy(eeprom_write_busy), .fuse_low_prog(fuse_low_prog),
    .fuse_high_prog(fuse_high_prog), .lock_prog(lock_prog),
    .cpu_stall(cpu_stall), .lpm_hit(lpm_hit), .lpm_data(lpm_data),
    .flash_erase_start(flash_erase_start), .flash_prog_we(flash_prog_we),
    .flash_page(flash_page), .flash_prog_addr(flash_prog_addr),
    .flash_prog_data(flash_prog_data));

  fspc_cpu_model fspc_cpu_model_i (
    .hclk(hclk), .cpu_stall(cpu_stall), .lpm_hit(lpm_hit),
    .lpm_data(lpm_data), .spm_req(spm_req), .lpm_req(lpm_req),
    .ptr(ptr), .data_pair(data_pair));

  always #5 hclk = ~hclk;

  // flash side capture and stall length, sampled before the edge lands
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    scnt <= (cpu_stall === 1'b1) ? scnt + 1 : 0;
    if (cpu_stall === 1'b0 && scnt != 0) begin
      slen <= scnt;
    end
    if (flash_prog_we === 1'b1) begin
      cap[flash_prog_addr] <= flash_prog_data;
      wpage <= flash_page;
      wcnt <= wcnt + 1;
    end
    if (flash_erase_start === 1'b1) begin
      epage <= flash_page;
      ecnt <= ecnt + 1;
    end
    if (cyc > 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask

  task automatic ahb(input logic [31:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(logic [31:0] a, logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'b1, d, r);
  endtask

  task automatic rd(logic [31:0] a, logic [31:0] e);
    logic [31:0] r;
    ahb(a, 1'b0, 32'h0, r);
    chk("rdata", e, r);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic store(logic [15:0] p, logic [15:0] d);
    fspc_cpu_model_i.issue(1'b0, p, d);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < PW; i++) begin
      exp_buf[i] = 16'hFFFF;
    end
  endtask

  task automatic idle();
    int n;
    n = 0;
    while (cpu_stall !== 1'b0 && n < 200) begin
      @(posedge hclk);
      #1;
      n++;
    end
    @(posedge hclk);
    #1;
  endtask

  task automatic fill(logic [11:0] p, int n);
    logic [15:0] d;
    for (int i = 0; i < n; i++) begin
      d = 16'($urandom);
      exp_buf[i] = d;
      wr(ADDR_CTRL, 32'h1);
      store({p, i[2:0], 1'($urandom)}, d);
    end
  endtask

  task automatic pgwrite(logic [11:0] p);
    int w0;
    w0 = wcnt;
    wr(ADDR_CTRL, 32'h5);
    store({p, 4'h0}, 16'($urandom));
    rd(ADDR_CTRL, 32'h5);
    idle();
    chk("stall", OPC, slen);
    chk("wcnt", PW, wcnt - w0);
    chk("wpage", p, wpage);
    for (int i = 0; i < PW; i++) begin
      chk("word", exp_buf[i], cap[i]);
      exp_buf[i] = 16'hFFFF;
    end
    rd(ADDR_CTRL, 32'h0);
  endtask

  function automatic logic [7:0] fuse_exp(logic [1:0] p);
    case (p)
      2'h1:    return {6'h3F, ~lock_prog};
      2'h3:    return ~fuse_high_prog;
      default: return ~fuse_low_prog;
    endcase
  endfunction

  function automatic logic ok_cmd(logic [4:0] c);
    return c inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h11};
  endfunction

  initial begin
    logic [7:0] cmds [4];
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    eeprom_write_busy = 1'b0;
    void'($urandom(32'hDFFE));
    fuse_low_prog = 8'($urandom);
    fuse_high_prog = 8'($urandom);
    lock_prog = 2'($urandom);
    cmds = '{8'h05, 8'h03, 8'h09, 8'h01};
    do_reset();
    rd(ADDR_CTRL, 32'h0);
    rd(32'h40, 32'h0);
    $display("test reset done");
    repeat (6) begin
      do v = 8'($urandom); while (ok_cmd(v[4:0]));
      wr(ADDR_CTRL, {24'h0, v});
      store(16'($urandom), 16'($urandom));
      rd(ADDR_CTRL, 32'h0);
    end
    foreach (cmds[i]) begin
      wr(ADDR_CTRL, {24'h0, cmds[i]});
      rd(ADDR_CTRL, {24'h0, cmds[i]});
      repeat (4) @(posedge hclk);
      rd(ADDR_CTRL, 32'h0);
      store(16'h0010, 16'h0);
    end
    repeat (3) @(posedge hclk);
    chk("no_op", 0, wcnt + ecnt);
    $display("test window done");
    pg = 12'($urandom);
    fill(pg, PW);
    rd(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    store({pg, 4'($urandom)}, 16'($urandom));
    rd(ADDR_CTRL, 32'h3);
    rd(ADDR_STAT, 32'h3);
    idle();
    chk("erase", 1, ecnt);
    chk("epage", pg, epage);
    chk("estall", OPC, slen);
    rd(ADDR_CTRL, 32'h0);
    pgwrite(pg);
    pgwrite(pg);
    $display("test program done");
    fill(pg, 3);
    wr(ADDR_CTRL, 32'h11);
    for (int i = 0; i < PW; i++) begin
      exp_buf[i] = 16'hFFFF;
    end
    pgwrite(pg);
    fill(pg, 3);
    eeprom_write_busy <= 1'b1;
    repeat (2) @(posedge hclk);
    wr(ADDR_CTRL, 32'h3);
    rd(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h9);
    fspc_cpu_model_i.load(16'h0001, hit, v);
    chk("busy_hit", 0, hit);
    // software waits for the EEPROM to finish first
    eeprom_write_busy <= 1'b0;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < PW; i++) begin
      exp_buf[i] = 16'hFFFF;
    end
    pgwrite(pg);
    $display("test clear done");
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CTRL, 32'h9);
      fspc_cpu_model_i.load(16'(p), hit, v);
      chk("hit", 1, hit);
      chk("fuse", fuse_exp(2'(p)), v);
    end
    $display("test fuse done");
    fill(pg, 2);
    do_reset();
    rd(ADDR_CTRL, 32'h0);
    pgwrite(pg);
    $display("test rerun done");
    end_sim();
  end
endmodule
